// *** flow_valve_control_regs.v ***
// Valve control register bank with APB slave, action sequencer and status LED
//
// Functional notes
// R01: Mode codes: 0 closed, 1 auto loop, 2 manual level, 3 analog input.
// R02: Mode is volatile; every startup begins in automatic loop mode.
// R03: LED blinks 1 Hz 500/500 ms in closed or manual mode, else lit.
// R04: LED also blinks the same way while status reports hardware force.
// R05: Status: 0 normal, 1 protection, 2 forced by hardware, 3 action running.
// R06: Any nonzero status raises warning 13, automatic valve control offline.
// R07: Drive level register reads present valve drive in percent.
// R08: Command write starts: 0 abort, 1 purge, 2 offset, 3 hold closed, 4 hold open.
// R09: New command aborts running one; zero aborts, harmless when idle.
// R10: Command reads running action code, zero when idle or finished.
// R11: Status reads busy code 3 for the whole action.
// R12: Finished offset detection returns valve to the mode register's mode.
// R13: Holds last until abort, new command, measurement left, or hardware force.
// R14: Manual level applies at once in manual mode, else stored only.
// R15: Manual level writes saturate to 0 below zero, 100 above 100.
// R16: Manual level is volatile, loaded from persistent copy at startup.
// R17: Manual control ignores configured minimum and maximum drive limits.
// R18: Purge duration in milliseconds; write applies now and is persisted.
// R19: Option bit 0 protection, bit 1 auto minimum; others ignored; persisted.
// R20: Drive type accepts -1, 0, 1 only; persisted, read back, used at restart.
// R21: Host software should enable the valve protection option.
// R22: Frequency reads selected type's PWM rate; ignored when type is positive.
// R23: Purge opens valve fully for the duration, then ends by itself.
`timescale 1ns/1ps
`default_nettype none
`include "valve_map.vh"
module flow_valve_control_regs #(
  parameter [31:0] MS_CYC    = `MS_CYCLES,
  parameter [31:0] BLINK_CYC = `BLINK_HALF_CYC
) (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        force_pin,
  input  wire        force_open_pin,
  input  wire        measurement_state,
  input  wire        protect_active,
  input  wire        offset_done,
  input  wire [15:0] offset_level,
  input  wire [15:0] auto_level,
  input  wire [15:0] analog_level,
  input  wire [15:0] drive_min,
  input  wire [15:0] drive_max,
  input  wire [15:0] nv_manual_level,
  input  wire [15:0] nv_flush_ms,
  input  wire [15:0] nv_options,
  input  wire [15:0] nv_drive_type,
  input  wire [15:0] nv_frequency,
  output reg  [15:0] drive_level_r,
  output reg         offset_run_r,
  output reg         led_r,
  output reg  [15:0] warn_code_r,
  output reg  [1:0]  option_en_r,
  output reg  [15:0] active_dtype_r,
  output reg  [15:0] active_freq_r,
  output reg         persist_we_r,
  output reg  [9:0]  persist_idx_r,
  output reg  [15:0] persist_data_r
);

  // ==================================================================
  // Helpers
  // Saturate an unsigned percent into [lo, hi]
  // Inclusive bounds; the caller keeps lo at or below hi
  function [15:0] clamp_pct;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (v < lo) begin
        clamp_pct = lo;
      end else if (v > hi) begin
        clamp_pct = hi;
      end else begin
        clamp_pct = v;
      end
    end
  endfunction

  // Signed manual write saturated to 0..100
  // Negative host values arrive as two's complement and clamp to zero
  function [15:0] sat_manual;
    input [15:0] v;
    begin
      if (v[15]) begin
        sat_manual = `PCT_ZERO;
      end else begin
        sat_manual = clamp_pct(v, `PCT_ZERO, `PCT_FULL);
      end
    end
  endfunction

  // ==================================================================
  // State
  // Configuration, sequencer, synchroniser and LED timing registers
  reg  [1:0]  mode_r;
  reg  [1:0]  cond_r;
  reg  [15:0] manual_r;
  reg  [2:0]  cmd_r;
  reg  [15:0] flush_r;
  reg  [15:0] dtype_r;
  reg  [15:0] freq_r;
  reg         init_done_r;
  reg  [2:0]  pin_s1_r;
  reg  [2:0]  pin_s2_r;
  reg  [2:0]  pin_s3_r;
  reg  [2:0]  pin_f_r;
  reg  [15:0] flush_left_r;
  reg  [31:0] ms_cnt_r;
  reg  [31:0] blink_cnt_r;
  reg         blink_ph_r;
  reg  [15:0] level_nxt;
  reg  [1:0]  cond_nxt;
  reg  [31:0] rd_nxt;
  reg         hit_nxt;

  wire [9:0]  idx      = paddr[11:2];
  wire        access   = psel & penable & ~pready;
  wire        wr_fire  = psel & penable & pready & pwrite & ~pslverr;
  wire [15:0] wd       = pwdata[15:0];
  wire        forced   = pin_f_r[0];
  wire        meas_on  = pin_f_r[2];
  wire        dtype_ok = (wd == `DTYPE_CUSTOM) || (wd == `DTYPE_PWM) || (wd == `DTYPE_LINEAR);

  // ==================================================================
  // Pin synchronisers: a change counts once stages two and three agree
  // Bit 0 force, bit 1 force direction, bit 2 measurement state
  // Four cycles of latency is far below any valve or status reaction time
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      pin_s3_r <= 3'h0;
      pin_f_r  <= 3'h0;
    end else begin
      pin_s1_r <= {measurement_state, force_open_pin, force_pin};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r  <= (pin_s3_r & ~(pin_s2_r ^ pin_s3_r)) | (pin_f_r & (pin_s2_r ^ pin_s3_r));
    end
  end

  // ==================================================================
  // APB read decode and error check
  // Unused upper bits read as zero; an unmapped index answers with an error
  always @* begin
    rd_nxt  = 32'h0000_0000;
    hit_nxt = 1'b1;
    case (idx)
      `IDX_MODE:   rd_nxt[1:0]  = mode_r;          // [R01]
      `IDX_COND:   rd_nxt[1:0]  = cond_r;          // [R05]
      `IDX_LEVEL:  rd_nxt[15:0] = drive_level_r;   // [R07]
      `IDX_MANUAL: rd_nxt[15:0] = manual_r;
      `IDX_CMD:    rd_nxt[2:0]  = cmd_r;           // [R10]
      `IDX_FLUSH:  rd_nxt[15:0] = flush_r;
      `IDX_OPTION: rd_nxt[1:0]  = option_en_r;
      `IDX_DTYPE:  rd_nxt[15:0] = dtype_r;         // [R20]
      `IDX_FREQ:   rd_nxt[15:0] = freq_r;          // [R22]
      default:     hit_nxt      = 1'b0;
    endcase
    // Read-only registers refuse writes
    if (pwrite && (idx == `IDX_COND || idx == `IDX_LEVEL)) begin
      hit_nxt = 1'b0;
    end
  end

  // One wait state: answer in the second access cycle
  // Registered answer keeps the bus outputs glitch free; writes read back zero
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access & ~hit_nxt;
      if (access) begin
        prdata <= (pwrite || !hit_nxt) ? 32'h0000_0000 : rd_nxt;
      end
    end
  end

  // ==================================================================
  // Configuration registers, startup load from persistent copies
  // The store strobe lasts one cycle; the persistent side must take it at once
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_done_r    <= 1'b0;
      mode_r         <= `MODE_AUTO;                // [R02]
      manual_r       <= `PCT_ZERO;
      flush_r        <= 16'h0000;
      option_en_r    <= 2'h0;
      dtype_r        <= `DTYPE_PWM;
      freq_r         <= 16'h0000;
      active_dtype_r <= `DTYPE_PWM;
      active_freq_r  <= 16'h0000;
      persist_we_r   <= 1'b0;
      persist_idx_r  <= 10'h000;
      persist_data_r <= 16'h0000;
    end else begin
      persist_we_r <= 1'b0;
      if (!init_done_r) begin
        // Restart-applied settings are caught once, after reset release
        // Mode is never persisted, so it keeps its automatic reset value
        init_done_r    <= 1'b1;
        manual_r       <= sat_manual(nv_manual_level); // [R16]
        flush_r        <= nv_flush_ms;
        option_en_r    <= nv_options[1:0];
        dtype_r        <= nv_drive_type;
        freq_r         <= nv_frequency;
        active_dtype_r <= nv_drive_type;           // [R20]
        active_freq_r  <= nv_frequency;            // [R22]
      end else if (wr_fire) begin
        case (idx)
          `IDX_MODE: mode_r <= wd[1:0];            // [R01] [R02]
          `IDX_MANUAL: manual_r <= sat_manual(wd); // [R14] [R15]
          `IDX_FLUSH: begin
            flush_r        <= wd;                  // [R18]
            persist_we_r   <= 1'b1;
            persist_idx_r  <= `IDX_FLUSH;
            persist_data_r <= wd;
          end
          `IDX_OPTION: begin
            // Unsupported bits are simply dropped
            option_en_r    <= wd[1:0];             // [R19]
            persist_we_r   <= 1'b1;
            persist_idx_r  <= `IDX_OPTION;
            persist_data_r <= wd & `OPT_MASK;
          end
          `IDX_DTYPE: begin
            if (dtype_ok) begin                    // [R20]
              dtype_r        <= wd;
              persist_we_r   <= 1'b1;
              persist_idx_r  <= `IDX_DTYPE;
              persist_data_r <= wd;
            end
          end
          `IDX_FREQ: begin
            // A positive type code locks the frequency
            if (dtype_r[15] || dtype_r == `DTYPE_PWM) begin // [R22]
              freq_r         <= wd;
              persist_we_r   <= 1'b1;
              persist_idx_r  <= `IDX_FREQ;
              persist_data_r <= wd;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ==================================================================
  // Action sequencer; a write in the same cycle as an end wins, except against a forced end
  // Purge ends on its own timer; holds and offset search end on outside events
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r        <= `CMD_NONE;
      flush_left_r <= 16'h0000;
      ms_cnt_r     <= 32'h0000_0000;
      offset_run_r <= 1'b0;
    end else begin
      // Millisecond tick for the purge timer
      // A zero purge time still runs for one millisecond tick
      if (cmd_r == `CMD_FLUSH) begin
        if (ms_cnt_r >= MS_CYC - 32'd1) begin
          ms_cnt_r <= 32'h0000_0000;
          if (flush_left_r <= 16'h0001) begin
            cmd_r <= `CMD_NONE;                    // [R23]
          end
          flush_left_r <= flush_left_r - 16'h0001;
        end else begin
          ms_cnt_r <= ms_cnt_r + 32'd1;
        end
      end
      if (cmd_r == `CMD_OFFSET && offset_done) begin
        cmd_r <= `CMD_NONE;                        // [R12]
      end
      if ((cmd_r == `CMD_HOLD_CLOSE || cmd_r == `CMD_HOLD_OPEN) && !meas_on) begin
        cmd_r <= `CMD_NONE;                        // [R13]
      end
      // Hardware force takes the valve over and ends any action
      // Commands are refused while forced, so the forced level cannot be left
      if (forced) begin
        cmd_r <= `CMD_NONE;                        // [R13]
      end else if (wr_fire && idx == `IDX_CMD && wd <= `CMD_MAX) begin
        cmd_r        <= wd[2:0];                   // [R08] [R09]
        ms_cnt_r     <= 32'h0000_0000;
        flush_left_r <= flush_r;                   // [R23]
      end
      offset_run_r <= (cmd_r == `CMD_OFFSET) && !forced;
    end
  end

  // ==================================================================
  // Drive level and status selection
  // Priority: forced, then busy, then protection, then normal operation
  always @* begin
    level_nxt = `PCT_ZERO;
    cond_nxt  = `COND_NORMAL;
    if (forced) begin
      level_nxt = pin_f_r[1] ? `PCT_FULL : `PCT_ZERO;
      cond_nxt  = `COND_FORCED;                    // [R05]
    end else if (cmd_r != `CMD_NONE) begin
      cond_nxt = `COND_BUSY;                       // [R11]
      case (cmd_r)
        `CMD_FLUSH:     level_nxt = `PCT_FULL;     // [R23]
        `CMD_OFFSET:    level_nxt = clamp_pct(offset_level, `PCT_ZERO, `PCT_FULL);
        `CMD_HOLD_OPEN: level_nxt = `PCT_FULL;
        default:        level_nxt = `PCT_ZERO;
      endcase
    end else begin
      if (protect_active && option_en_r[`OPT_PROTECT_BIT]) begin
        cond_nxt = `COND_PROTECT;                  // [R05]
      end
      case (mode_r)
        `MODE_AUTO:   level_nxt = clamp_pct(auto_level, drive_min, drive_max);
        `MODE_MANUAL: level_nxt = manual_r;        // [R14] [R17]
        `MODE_ANALOG: level_nxt = clamp_pct(analog_level, drive_min, drive_max);
        default:      level_nxt = `PCT_ZERO;       // [R01]
      endcase
    end
  end

  // Level, status and warning share one edge so they never disagree
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_level_r <= `PCT_ZERO;
      cond_r        <= `COND_NORMAL;
      warn_code_r   <= 16'h0000;
    end else begin
      drive_level_r <= level_nxt;                  // [R07]
      cond_r        <= cond_nxt;
      warn_code_r   <= (cond_nxt != `COND_NORMAL) ? `WARN_OFFLINE : 16'h0000; // [R06]
    end
  end

  // ==================================================================
  // Status LED: free-running 500 ms phase so blinking is always 1 Hz
  // Entering a blinking mode mid-phase shortens only the first half period
  // Outside the blinking cases the LED is dark only while reset is held
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_ph_r  <= 1'b1;
      led_r       <= 1'b0;
    end else begin
      if (blink_cnt_r >= BLINK_CYC - 32'd1) begin
        blink_cnt_r <= 32'h0000_0000;
        blink_ph_r  <= ~blink_ph_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 32'd1;
      end
      if (mode_r == `MODE_CLOSED || mode_r == `MODE_MANUAL || cond_r == `COND_FORCED) begin
        led_r <= blink_ph_r;                       // [R03] [R04]
      end else begin
        led_r <= 1'b1;                             // [R03]
      end
    end
  end

endmodule
`default_nettype wire

// *** flow_valve_control_regs_assertions.sv ***
// Port checker for the valve register bank
`timescale 1ns/1ps
`default_nettype none
`include "valve_map.vh"
module flow_valve_control_regs_assertions #(
  parameter [31:0] MS_CYC    = 4,
  parameter [31:0] BLINK_CYC = 8
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] drive_level_r,
  input wire logic        offset_run_r,
  input wire logic        led_r,
  input wire logic [15:0] warn_code_r,
  input wire logic [1:0]  option_en_r,
  input wire logic        persist_we_r,
  input wire logic [9:0]  persist_idx_r
);
  // ====================================================================
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ====================================================================
  // Bus answer and read-only places
  a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_rdata_upper: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_cond_ro: assert property (pready && pwrite && paddr[11:2] == `IDX_COND |-> pslverr)
    else $error("status write not refused");
  a_level_ro: assert property (pready && pwrite && paddr[11:2] == `IDX_LEVEL |-> pslverr)
    else $error("drive level write not refused");

  // ====================================================================
  // Drive, warning and LED behaviour
  a_level_max: assert property (drive_level_r <= `PCT_FULL)
    else $error("drive level above full scale");
  a_warn_code: assert property (warn_code_r == `PCT_ZERO || warn_code_r == `WARN_OFFLINE)
    else $error("warning code not 0 or 13");
  // Two cycles of slack: status and warning trail the action start
  a_busy_warn: assert property (offset_run_r ##1 offset_run_r ##1 offset_run_r |-> warn_code_r == `WARN_OFFLINE)
    else $error("no warning while action runs");
  a_led_half: assert property ($rose(led_r) |-> led_r [*8])
    else $error("led on phase shorter than half period");

  // ====================================================================
  // Persistent writes
  a_opt_store: assert property (pready && pwrite && paddr[11:2] == `IDX_OPTION |=>
    persist_we_r && persist_idx_r == `IDX_OPTION && option_en_r == $past(pwdata[1:0]))
    else $error("option write not applied and stored");
  a_store_pulse: assert property (persist_we_r |=> !persist_we_r)
    else $error("store strobe longer than one cycle");
endmodule
bind flow_valve_control_regs flow_valve_control_regs_assertions #(.MS_CYC(MS_CYC), .BLINK_CYC(BLINK_CYC)) chk_i (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .drive_level_r(drive_level_r), .offset_run_r(offset_run_r), .led_r(led_r), .warn_code_r(warn_code_r),
  .option_en_r(option_en_r), .persist_we_r(persist_we_r), .persist_idx_r(persist_idx_r));
`default_nettype wire

// *** flow_valve_control_regs_tb_top.sv ***
// Self-checking bench for the valve register bank
`timescale 1ns/1ps
`default_nettype none
`include "valve_map.vh"
module flow_valve_control_regs_tb_top;
  logic        core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic        force_pin = 0, force_open_pin = 0, measurement_state = 1, protect_active = 0;
  logic [15:0] auto_level = 16'h0014, analog_level = 16'h0028, drive_min = 16'h000A, drive_max = 16'h0032;
  logic [15:0] nv_manual_level = 16'h002A, nv_flush_ms = 16'h0003, nv_options = 16'h0002;
  logic [15:0] nv_drive_type = 16'h0000, nv_frequency = 16'h1B58, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, offset_done, offset_run_r, led_r, persist_we_r;
  wire  [15:0] offset_level, drive_level_r, warn_code_r, active_dtype_r, active_freq_r, persist_data_r;
  wire  [1:0]  option_en_r;
  wire  [9:0]  persist_idx_r;
  int          fail_count = 0, checks = 0;

  // ====================================================================
  // Clock, design and valve
  always #2.5 core_clk = ~core_clk;
  flow_valve_control_regs #(.MS_CYC(32'd4), .BLINK_CYC(32'd8)) flow_valve_control_regs_i (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .force_pin(force_pin),
    .force_open_pin(force_open_pin), .measurement_state(measurement_state), .protect_active(protect_active),
    .offset_done(offset_done), .offset_level(offset_level), .auto_level(auto_level),
    .analog_level(analog_level), .drive_min(drive_min), .drive_max(drive_max),
    .nv_manual_level(nv_manual_level), .nv_flush_ms(nv_flush_ms), .nv_options(nv_options),
    .nv_drive_type(nv_drive_type), .nv_frequency(nv_frequency), .drive_level_r(drive_level_r),
    .offset_run_r(offset_run_r), .led_r(led_r), .warn_code_r(warn_code_r), .option_en_r(option_en_r),
    .active_dtype_r(active_dtype_r), .active_freq_r(active_freq_r), .persist_we_r(persist_we_r),
    .persist_idx_r(persist_idx_r), .persist_data_r(persist_data_r));
  valve_model valve_model_i (.core_clk(core_clk), .rst_n(rst_n), .offset_run_r(offset_run_r),
    .offset_done(offset_done), .offset_level(offset_level));

  // ====================================================================
  // Shared tasks
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Request stands until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [9:0] ix, input logic [15:0] d, input logic err = 1'b0);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata[15:0];
    cmp("pready", 16'h0001, {15'h0, pready});
    cmp("pslverr", {15'h0, err}, {15'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] ix, input logic [15:0] d);
    apb(1'b1, ix, d);
  endtask
  task automatic rdc(input logic [9:0] ix, input logic [15:0] e, input string nm);
    apb(1'b0, ix, 16'h0000);
    cmp(nm, e, rd);
  endtask
  // Drive trails its cause by a cycle, so let a few edges pass
  task automatic chk_drive(input logic [15:0] e);
    repeat (3) @(posedge core_clk);
    cmp("drive", e, drive_level_r);
  endtask
  task automatic led_low(input logic [15:0] e);
    int c = 0;
    repeat (20) @(posedge core_clk);
    repeat (32) begin
      @(posedge core_clk);
      c += (led_r === 1'b0);
    end
    cmp("led low cycles", e, c[15:0]);
  endtask

  // ====================================================================
  // Scenarios
  task automatic t_reset;
    rdc(`IDX_MODE, {14'h0, `MODE_AUTO}, "mode");
    rdc(`IDX_MANUAL, nv_manual_level, "manual");
    rdc(`IDX_FLUSH, nv_flush_ms, "flush");
    rdc(`IDX_OPTION, nv_options, "option");
    rdc(`IDX_DTYPE, nv_drive_type, "dtype");
    led_low(16'h0000);
  endtask
  task automatic t_mode;
    for (int m = 3; m >= 0; m--) begin
      wr(`IDX_MODE, m[15:0]);
      rdc(`IDX_MODE, m[15:0], "mode");
      chk_drive(m == 0 ? `PCT_ZERO : m == 1 ? auto_level : m == 2 ? nv_manual_level : analog_level);
      led_low((m == 0 || m == 2) ? 16'h0010 : 16'h0000);
    end
  endtask
  task automatic t_manual;
    wr(`IDX_MANUAL, 16'h0050);
    chk_drive(`PCT_ZERO);
    wr(`IDX_MODE, {14'h0, `MODE_MANUAL});
    chk_drive(16'h0050);
    wr(`IDX_MANUAL, 16'h00C8);
    rdc(`IDX_MANUAL, `PCT_FULL, "manual");
    wr(`IDX_MANUAL, 16'hFFF6);
    rdc(`IDX_LEVEL, `PCT_ZERO, "level");
    rdc(`IDX_MANUAL, `PCT_ZERO, "manual");
    wr(`IDX_MODE, {14'h0, `MODE_AUTO});
  endtask
  task automatic t_cmd;
    wr(`IDX_CMD, {13'h0, `CMD_HOLD_OPEN});
    rdc(`IDX_CMD, {13'h0, `CMD_HOLD_OPEN}, "cmd");
    rdc(`IDX_COND, {14'h0, `COND_BUSY}, "cond");
    cmp("warn", `WARN_OFFLINE, warn_code_r);
    chk_drive(`PCT_FULL);
    wr(`IDX_CMD, {13'h0, `CMD_HOLD_CLOSE});
    chk_drive(`PCT_ZERO);
    wr(`IDX_CMD, 16'h0000);
    rdc(`IDX_CMD, 16'h0000, "cmd");
    wr(`IDX_CMD, 16'h0007);
    rdc(`IDX_COND, {14'h0, `COND_NORMAL}, "cond");
    cmp("warn", `PCT_ZERO, warn_code_r);
    wr(`IDX_CMD, {13'h0, `CMD_HOLD_OPEN});
    measurement_state <= 1'b0;
    repeat (8) @(posedge core_clk);
    rdc(`IDX_CMD, 16'h0000, "cmd");
    measurement_state <= 1'b1;
  endtask
  task automatic t_flush_offset;
    wr(`IDX_FLUSH, 16'h0002);
    rdc(`IDX_FLUSH, 16'h0002, "flush");
    wr(`IDX_CMD, {13'h0, `CMD_FLUSH});
    chk_drive(`PCT_FULL);
    repeat (16) @(posedge core_clk);
    rdc(`IDX_CMD, 16'h0000, "cmd");
    wr(`IDX_CMD, {13'h0, `CMD_OFFSET});
    rdc(`IDX_CMD, {13'h0, `CMD_OFFSET}, "cmd");
    cmp("offset run", 16'h0001, {15'h0, offset_run_r});
    repeat (20) @(posedge core_clk);
    rdc(`IDX_CMD, 16'h0000, "cmd");
    chk_drive(auto_level);
  endtask
  task automatic t_force;
    force_open_pin <= 1'b1;
    force_pin <= 1'b1;
    repeat (8) @(posedge core_clk);
    rdc(`IDX_COND, {14'h0, `COND_FORCED}, "cond");
    cmp("warn", `WARN_OFFLINE, warn_code_r);
    chk_drive(`PCT_FULL);
    led_low(16'h0010);
    force_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic t_options;
    wr(`IDX_OPTION, 16'hFFFF);
    rdc(`IDX_OPTION, `OPT_MASK, "option");
    cmp("persist data", `OPT_MASK, persist_data_r);
    protect_active <= 1'b1;
    rdc(`IDX_COND, {14'h0, `COND_PROTECT}, "cond");
    protect_active <= 1'b0;
    wr(`IDX_DTYPE, 16'h0005);
    rdc(`IDX_DTYPE, nv_drive_type, "dtype");
    wr(`IDX_DTYPE, `DTYPE_CUSTOM);
    rdc(`IDX_DTYPE, `DTYPE_CUSTOM, "dtype");
    cmp("active type", nv_drive_type, active_dtype_r);
    cmp("active freq", nv_frequency, active_freq_r);
    wr(`IDX_DTYPE, `DTYPE_LINEAR);
    wr(`IDX_FREQ, 16'h0100);
    rdc(`IDX_FREQ, nv_frequency, "freq");
    apb(1'b1, `IDX_COND, 16'h0001, 1'b1);
    apb(1'b1, `IDX_LEVEL, 16'h0001, 1'b1);
    apb(1'b0, 10'h100, 16'h0000, 1'b1);
  endtask

  // ====================================================================
  // Verdict, main sequence and watchdog
  task automatic conclude;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset;
    t_mode;
    t_manual;
    t_cmd;
    t_flush_offset;
    t_force;
    t_options;
    conclude;
  end
  initial begin
    repeat (6000) @(posedge core_clk);
    fail_count++;
    conclude;
  end
endmodule
`default_nettype wire

// *** valve_map.vh ***
// Register indices, field codes, reset values and timing counts for the valve register bank
`ifndef VALVE_MAP_VH
`define VALVE_MAP_VH
// ====================================================================
// Register indices (byte address is four times the index)
`define IDX_MODE        10'h160
`define IDX_COND        10'h161
`define IDX_LEVEL       10'h162
`define IDX_MANUAL      10'h164
`define IDX_CMD         10'h168
`define IDX_FLUSH       10'h174
`define IDX_OPTION      10'h176
`define IDX_DTYPE       10'h177
`define IDX_FREQ        10'h178
// ====================================================================
// Mode, condition and command codes
`define MODE_CLOSED     2'h0
`define MODE_AUTO       2'h1
`define MODE_MANUAL     2'h2
`define MODE_ANALOG     2'h3
`define COND_NORMAL     2'h0
`define COND_PROTECT    2'h1
`define COND_FORCED     2'h2
`define COND_BUSY       2'h3
`define CMD_NONE        3'h0
`define CMD_FLUSH       3'h1
`define CMD_OFFSET      3'h2
`define CMD_HOLD_CLOSE  3'h3
`define CMD_HOLD_OPEN   3'h4
`define CMD_MAX         16'h0004
// ====================================================================
// Field layout and values
`define OPT_PROTECT_BIT 0
`define OPT_AUTOMIN_BIT 1
`define OPT_MASK        16'h0003
`define DTYPE_CUSTOM    16'hFFFF
`define DTYPE_PWM       16'h0000
`define DTYPE_LINEAR    16'h0001
`define PCT_FULL        16'h0064
`define PCT_ZERO        16'h0000
`define WARN_OFFLINE    16'h000D
// ====================================================================
// Timing: times in their own unit, counts derived from the clock period
`define CLK_PERIOD_PS   5000
`define MS_PS           1000000000
`define BLINK_HALF_MS   500
`define MS_CYCLES       (`MS_PS / `CLK_PERIOD_PS)
`define BLINK_HALF_CYC  (`BLINK_HALF_MS * `MS_CYCLES)
`endif

// *** valve_model.sv ***
// Behavioural valve actuator that answers an offset search
`timescale 1ns/1ps
`default_nettype none
module valve_model #(
  parameter int    SEEK_CYC = 12,
  parameter [15:0] OPEN_LVL = 16'h001E
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        offset_run_r,
  output var  logic        offset_done,
  output var  logic [15:0] offset_level
);
  int cnt;
  // ====================================================================
  // Seat lifts a while after the search starts; slow so the running code can be read
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      offset_done <= 1'b0;
      offset_level <= ~OPEN_LVL;
    end else begin
      cnt <= offset_run_r ? cnt + 1 : 0;
      offset_done <= offset_run_r && cnt == SEEK_CYC;
      // Level means nothing outside the done pulse, so it keeps changing
      offset_level <= (offset_run_r && cnt == SEEK_CYC) ? OPEN_LVL : ~offset_level;
    end
  end
endmodule
`default_nettype wire
